/* sps_status.sv */
// Purpose: status flags and receive holding register of a serial port
// Assumes: line events arrive as one-cycle pulses on this clock
// Notes: modem and slave-select pins pass a three-stage synchroniser
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module sps_status (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic rx_char_done_i,
    input wire logic [8:0] rx_char_i,
    input wire logic rx_cmd_mark_i,
    input wire logic rx_busy_i,
    input wire logic break_edge_i,
    input wire logic frame_err_i,
    input wire logic parity_err_i,
    input wire logic repeat_max_i,
    input wire logic not_acknowledged_flag_i,
    input wire logic biphase_err_i,
    input wire logic underrun_i,
    input wire logic bit_tick_i,
    input wire logic tx_load_i,
    input wire logic tx_shift_empty_i,
    input wire logic rx_dma_dec_i,
    input wire logic tx_dma_dec_i,
    input wire logic [3:0] modem_i,
    output logic tx_holding_free_o,
    output logic tx_fully_drained_o,
    output logic rx_char_available_o,
    output logic [8:0] tx_char_o,
    output logic break_pending_o
);
    typedef struct packed {
        logic [31:0] rdata;
        logic [3:0] mode;
        logic rx_en;
        logic tx_en;
        logic rx_held;
        logic rx_char_available;
        logic [8:0] rx_char;
        logic rx_mark;
        logic thr_full;
        logic [8:0] thr;
        logic brk_cmd;
        logic [15:0] tout_val;
        logic [15:0] tout_cnt;
        logic tout_run;
        logic [15:0] rcr;
        logic [15:0] rncr;
        logic [15:0] tcr;
        logic [15:0] tncr;
        logic rx_dma_count_done;
        logic tx_dma_count_done;
        logic brk;
        logic ovr;
        logic frame;
        logic par;
        logic tout;
        logic repeat_limit_flag;
        logic not_acknowledged_flag;
        logic biphase_error_flag;
        logic under;
        logic [3:0] ic;
        logic slave_select_edge_flag;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] lvl;
    } sps_state_type;

    sps_state_type r;
    sps_state_type next_r;

    function automatic logic is_spi(input logic [3:0] m);
        is_spi = (m == sps_pkg::MODE_SPI_MASTER) ||
            (m == sps_pkg::MODE_SPI_SLAVE);
    endfunction

    function automatic logic hit(input logic [31:0] a,
        input logic [31:0] o);
        hit = (a == o);
    endfunction

    logic wr_cmd, wr_thr, rd_csr, rd_rhr, spi;
    logic wr_rcr, wr_rncr, wr_tcr, wr_tncr, clr_sta;
    logic [3:0] lvl_chg;
    logic [31:0] csr;

    always_comb begin
        wr_cmd = wr_i && hit(addr_i, sps_pkg::CTRL_CMD_OFS);
        wr_thr = wr_i && hit(addr_i, sps_pkg::THR_OFS);
        wr_rcr = wr_i && hit(addr_i, sps_pkg::RCR_OFS);
        wr_rncr = wr_i && hit(addr_i, sps_pkg::RNCR_OFS);
        wr_tcr = wr_i && hit(addr_i, sps_pkg::TCR_OFS);
        wr_tncr = wr_i && hit(addr_i, sps_pkg::TNCR_OFS);
        rd_csr = rd_i && hit(addr_i, sps_pkg::CSR_OFS);
        rd_rhr = rd_i && hit(addr_i, sps_pkg::RHR_OFS);
        clr_sta = wr_cmd && wdata_i[sps_pkg::CMD_CLR_STATUS];
        spi = is_spi(r.mode);
        // change counts once stages two and three agree
        lvl_chg = (r.s2 ~^ r.s3) & (r.s3 ^ r.lvl);
        csr = 32'h0000_0000;
        csr[sps_pkg::ST_RX_CHAR_AVAILABLE] = r.rx_char_available;
        csr[sps_pkg::ST_TX_HOLDING_FREE] = r.tx_en && !r.thr_full &&
            (spi || !r.brk_cmd);
        csr[sps_pkg::ST_RX_DMA_COUNT_DONE] = r.rx_dma_count_done;
        csr[sps_pkg::ST_TX_DMA_COUNT_DONE] = r.tx_dma_count_done;
        csr[sps_pkg::ST_OVR] = r.ovr;
        csr[sps_pkg::ST_TX_FULLY_DRAINED] = r.tx_en && !r.thr_full &&
            tx_shift_empty_i;
        csr[sps_pkg::ST_TX_DMA_BOTH_ZERO] = (r.tcr == 16'h0000) &&
            (r.tncr == 16'h0000);
        csr[sps_pkg::ST_RX_DMA_BOTH_ZERO] = (r.rcr == 16'h0000) &&
            (r.rncr == 16'h0000);
        if (spi) begin
            csr[sps_pkg::ST_UNDER] = r.under;
            csr[sps_pkg::ST_SLAVE_SELECT_EDGE_FLAG] = r.slave_select_edge_flag;
            csr[sps_pkg::ST_NSS] = r.lvl[3];
        end else begin
            csr[sps_pkg::ST_BRK] = r.brk;
            csr[sps_pkg::ST_FRAME] = r.frame;
            csr[sps_pkg::ST_PAR] = r.par;
            csr[sps_pkg::ST_TOUT] = r.tout;
            csr[sps_pkg::ST_REPEAT_LIMIT_FLAG] = r.repeat_limit_flag;
            csr[sps_pkg::ST_NOT_ACKNOWLEDGED_FLAG] = r.not_acknowledged_flag;
            csr[sps_pkg::ST_IC_LO +: 4] = r.ic;
            csr[sps_pkg::ST_LVL_LO +: 4] = r.lvl;
            csr[sps_pkg::ST_BIPHASE_ERROR_FLAG] = r.biphase_error_flag;
        end
    end

    always_comb begin
        next_r = r;
        next_r.s1 = modem_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.lvl = r.lvl ^ lvl_chg;
        next_r.rdata = 32'h0000_0000;
        if (rd_csr) begin
            next_r.rdata = csr;
        end
        if (rd_rhr) begin
            next_r.rdata[8:0] = r.rx_char;
            next_r.rdata[sps_pkg::RHR_MARK] = r.rx_mark;
        end
        if (wr_i && hit(addr_i, sps_pkg::MODE_OFS)) begin
            next_r.mode = wdata_i[3:0];
        end
        if (wr_i && hit(addr_i, sps_pkg::RTOR_OFS)) begin
            next_r.tout_val = wdata_i[15:0];
        end
        // clears first; sets below override them
        if (clr_sta) begin
            next_r.brk = 1'b0;
            next_r.ovr = 1'b0;
            next_r.frame = 1'b0;
            next_r.par = 1'b0;
            next_r.biphase_error_flag = 1'b0;
            next_r.under = 1'b0;
        end
        if (wr_cmd && wdata_i[sps_pkg::CMD_CLR_REPEAT]) begin
            next_r.repeat_limit_flag = 1'b0;
        end
        if (wr_cmd && wdata_i[sps_pkg::CMD_CLR_NOT_ACKNOWLEDGED_FLAG]) begin
            next_r.not_acknowledged_flag = 1'b0;
        end
        if (wr_cmd && wdata_i[sps_pkg::CMD_ARM_TIMER]) begin
            next_r.tout = 1'b0;
            next_r.tout_cnt = r.tout_val;
            next_r.tout_run = (r.tout_val != 16'h0000);
        end
        if (wr_cmd && wdata_i[sps_pkg::CMD_BREAK_BEGIN]) begin
            next_r.brk_cmd = 1'b1;
        end
        if (wr_cmd && wdata_i[sps_pkg::CMD_BREAK_END]) begin
            next_r.brk_cmd = 1'b0;
        end
        if (wr_cmd && wdata_i[sps_pkg::CMD_RXEN]) begin
            next_r.rx_en = 1'b1;
            if (r.rx_held) begin
                next_r.rx_char_available = 1'b1;
                next_r.rx_held = 1'b0;
            end
        end
        if (wr_cmd && wdata_i[sps_pkg::CMD_RXDIS]) begin
            next_r.rx_en = 1'b0;
            next_r.rx_held = rx_busy_i;
        end
        if (wr_cmd && wdata_i[sps_pkg::CMD_TXEN]) begin
            next_r.tx_en = 1'b1;
        end
        if (wr_cmd && wdata_i[sps_pkg::CMD_TXDIS]) begin
            next_r.tx_en = 1'b0;
        end
        if (rd_csr) begin
            next_r.ic = 4'h0;
            next_r.slave_select_edge_flag = 1'b0;
        end
        if (rd_rhr) begin
            next_r.rx_char_available = 1'b0;
        end
        if (wr_thr) begin
            next_r.thr_full = 1'b1;
            next_r.thr = wdata_i[8:0];
        end else if (tx_load_i) begin
            next_r.thr_full = 1'b0;
        end
        // dma counters
        if (wr_rcr) begin
            next_r.rcr = wdata_i[15:0];
            next_r.rx_dma_count_done = 1'b0;
        end else if (rx_dma_dec_i && r.rcr != 16'h0000) begin
            next_r.rcr = r.rcr - 16'h0001;
            next_r.rx_dma_count_done = (r.rcr == 16'h0001) || r.rx_dma_count_done;
        end
        if (wr_rncr) begin
            next_r.rncr = wdata_i[15:0];
            next_r.rx_dma_count_done = 1'b0;
        end
        if (wr_tcr) begin
            next_r.tcr = wdata_i[15:0];
            next_r.tx_dma_count_done = 1'b0;
        end else if (tx_dma_dec_i && r.tcr != 16'h0000) begin
            next_r.tcr = r.tcr - 16'h0001;
            next_r.tx_dma_count_done = (r.tcr == 16'h0001) || r.tx_dma_count_done;
        end
        if (wr_tncr) begin
            next_r.tncr = wdata_i[15:0];
            next_r.tx_dma_count_done = 1'b0;
        end
        // idle timer counts bit periods
        if (r.tout_run && bit_tick_i) begin
            if (r.tout_cnt == 16'h0001) begin
                next_r.tout_run = 1'b0;
                next_r.tout = 1'b1;
            end else begin
                next_r.tout_cnt = r.tout_cnt - 16'h0001;
            end
        end
        if (rx_char_done_i) begin
            if (r.rx_char_available) begin
                next_r.ovr = 1'b1;
            end
            if (r.rx_en) begin
                next_r.rx_char_available = 1'b1;
            end else begin
                next_r.rx_held = 1'b1;
            end
            next_r.rx_char = rx_char_i;
            next_r.rx_mark = rx_cmd_mark_i;
        end
        if (break_edge_i) next_r.brk = 1'b1;
        if (frame_err_i) next_r.frame = 1'b1;
        if (parity_err_i) next_r.par = 1'b1;
        if (repeat_max_i) next_r.repeat_limit_flag = 1'b1;
        if (not_acknowledged_flag_i) next_r.not_acknowledged_flag = 1'b1;
        if (biphase_err_i) next_r.biphase_error_flag = 1'b1;
        if (underrun_i && spi) next_r.under = 1'b1;
        next_r.ic = next_r.ic | lvl_chg;
        if (lvl_chg[3]) next_r.slave_select_edge_flag = 1'b1;
        if (!reset_n_i) begin
            next_r = '0;
            next_r.tout_val = sps_pkg::TOUT_RESET;
            next_r.rcr = sps_pkg::CNT_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        r <= next_r;
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            tx_holding_free_o <= 1'b0;
            tx_fully_drained_o <= 1'b0;
            rx_char_available_o <= 1'b0;
            tx_char_o <= 9'h000;
            break_pending_o <= 1'b0;
        end else begin
            tx_holding_free_o <= csr[sps_pkg::ST_TX_HOLDING_FREE];
            tx_fully_drained_o <= csr[sps_pkg::ST_TX_FULLY_DRAINED];
            rx_char_available_o <= r.rx_char_available;
            tx_char_o <= r.thr;
            break_pending_o <= r.brk_cmd;
        end
    end

    assign rdata_o = r.rdata;

    a_break_sticky: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        break_edge_i |=> r.brk) else $error("break flag not set");
    a_ovr_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        r.ovr && !clr_sta |=> r.ovr) else $error("overrun lost");
    a_frame_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        frame_err_i |=> r.frame) else $error("framing not set");
    a_par_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        parity_err_i ##1 !clr_sta |=> r.par) else $error("parity lost");
    a_tout_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_cmd && wdata_i[sps_pkg::CMD_ARM_TIMER] |=> !r.tout)
        else $error("timeout not cleared");
    a_empty_thr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_thr |=> !csr[sps_pkg::ST_TX_FULLY_DRAINED]) else $error("tx_fully_drained high");
    a_repeat_limit_flag_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        repeat_max_i |=> r.repeat_limit_flag) else $error("repeat flag not set");
    a_not_acknowledged_flag_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        not_acknowledged_flag_i |=> r.not_acknowledged_flag) else $error("not_acknowledged_flag flag not set");
    a_rx_char_available_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rd_rhr && !rx_char_done_i |=> !r.rx_char_available) else $error("rx_char_available kept");
    a_ready_out: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_thr |=> ##1 !tx_holding_free_o) else $error("tx_holding_free high");
endmodule

/* sps_pkg.sv */
// Purpose: constants for the serial port status and receive holding block
// Assumes: 50 MHz clock, plain register port with one-cycle read latency
// Notes: offsets are byte addresses; registers are one 32-bit word each
// Notes on behaviour
// - break start or end sets sticky flag
// - rx dma count zero sets done flag
// - tx dma count zero sets done flag
// - overrun flag sticky until status clear
// - low stop bit sets framing error flag
// - parity failure sets sticky parity flag
// - timeout after arm sets flag, zero disables
// - tx drained only when holding and shifter empty
// - repeat limit flag cleared by repeat command
// - both dma counters zero give level flags
// - not acknowledged flag sticky until its clear
// - modem line changes flagged, cleared on read
// - modem line levels shown as status
// - biphase error flag sticky until status clear
// - spi layout only for mode 0xe or 0xf
// - spi underflow flag sticky until status clear
// - slave select edge flagged, cleared on read
// - slave select level shown beside edge flag
// - rx char available until holding read
// - tx holding free follows holding and enable
// - holding gives char bits 8:0, marker bit 15
// - break command pending holds tx ready low, except in spi modes
package sps_pkg;
    localparam logic [31:0] CTRL_CMD_OFS = 32'h400a0000;
    localparam logic [31:0] MODE_OFS = 32'h400a0004;
    localparam logic [31:0] CSR_OFS = 32'h400a0014;
    localparam logic [31:0] RHR_OFS = 32'h400a0018;
    localparam logic [31:0] THR_OFS = 32'h400a001c;
    localparam logic [31:0] RTOR_OFS = 32'h400a0024;
    localparam logic [31:0] RCR_OFS = 32'h400a0104;
    localparam logic [31:0] TCR_OFS = 32'h400a010c;
    localparam logic [31:0] RNCR_OFS = 32'h400a0114;
    localparam logic [31:0] TNCR_OFS = 32'h400a011c;
    // command bits
    localparam int CMD_RXEN = 4;
    localparam int CMD_RXDIS = 5;
    localparam int CMD_TXEN = 6;
    localparam int CMD_TXDIS = 7;
    localparam int CMD_CLR_STATUS = 8;
    localparam int CMD_BREAK_BEGIN = 9;
    localparam int CMD_BREAK_END = 10;
    localparam int CMD_ARM_TIMER = 11;
    localparam int CMD_CLR_NOT_ACKNOWLEDGED_FLAG = 14;
    localparam int CMD_CLR_REPEAT = 13;
    // status bit positions
    localparam int ST_RX_CHAR_AVAILABLE = 0;
    localparam int ST_TX_HOLDING_FREE = 1;
    localparam int ST_BRK = 2;
    localparam int ST_RX_DMA_COUNT_DONE = 3;
    localparam int ST_TX_DMA_COUNT_DONE = 4;
    localparam int ST_OVR = 5;
    localparam int ST_FRAME = 6;
    localparam int ST_PAR = 7;
    localparam int ST_TOUT = 8;
    localparam int ST_TX_FULLY_DRAINED = 9;
    localparam int ST_REPEAT_LIMIT_FLAG = 10;
    localparam int ST_UNDER = 10;
    localparam int ST_TX_DMA_BOTH_ZERO = 11;
    localparam int ST_RX_DMA_BOTH_ZERO = 12;
    localparam int ST_NOT_ACKNOWLEDGED_FLAG = 13;
    localparam int ST_IC_LO = 16;
    localparam int ST_LVL_LO = 20;
    localparam int ST_SLAVE_SELECT_EDGE_FLAG = 19;
    localparam int ST_NSS = 23;
    localparam int ST_BIPHASE_ERROR_FLAG = 24;
    localparam int RHR_MARK = 15;
    localparam logic [3:0] MODE_SPI_MASTER = 4'he;
    localparam logic [3:0] MODE_SPI_SLAVE = 4'hf;
    localparam logic [15:0] TOUT_RESET = 16'h0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
endpackage

/* sps_line_model.sv */
// Purpose: far-side model: remote transmitter and modem lines
// Assumes: one character per go request, modem pins asynchronous
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
module sps_line_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [9:0] chr_i,
    input wire logic [3:0] lvl_i,
    output logic done_o,
    output logic [8:0] chr_o,
    output logic mark_o,
    output logic [3:0] modem_o
);
    logic slow = 1'b0;
    initial begin
        done_o = 1'b0;
        chr_o = 9'h000;
        mark_o = 1'b0;
        modem_o = 4'h0;
    end
    // pins move off the clock grid
    always @(lvl_i) modem_o <= #7 lvl_i;
    // alternate prompt and slow delivery
    always @(posedge clk_i) begin
        if (go_i) begin
            if (slow) repeat (2) @(posedge clk_i);
            chr_o <= chr_i[8:0];
            mark_o <= chr_i[9];
            done_o <= 1'b1;
            slow <= ~slow;
            @(posedge clk_i);
            done_o <= 1'b0;
            chr_o <= ~chr_o;
            mark_o <= ~mark_o;
        end
    end
endmodule

/* sps_status_tb_top.sv */
// Purpose: self-checking bench for the status and receive holding block
// Assumes: reads are noted in a queue and checked when data appear
// Notes: modem levels settle within eight cycles
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module sps_status_tb_top;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [31:0] addr_i = 32'h0, wdata_i = 32'h0, rdata_o, e, m, se, ce, cm;
    logic thf, tfd, rca, bpo;
    logic [8:0] tco;
    logic wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0, busy = 1'b0, shm = 1'b1;
    logic [10:0] pv = 11'h000;
    logic go = 1'b0, done, mk;
    logic [9:0] chr = 10'h000, c1;
    logic [8:0] rch;
    logic [3:0] lvl = 4'h0, mdm, nl;
    logic [15:0] rnd = 16'hcfd6;
    logic [31:0] exp_q[$], msk_q[$];
    int fails = 0, n_compared = 0;
    int sb[6] = '{sps_pkg::ST_BRK, sps_pkg::ST_FRAME, sps_pkg::ST_PAR,
        sps_pkg::ST_REPEAT_LIMIT_FLAG, sps_pkg::ST_NOT_ACKNOWLEDGED_FLAG, sps_pkg::ST_BIPHASE_ERROR_FLAG};
    int cb[6] = '{sps_pkg::CMD_CLR_STATUS, sps_pkg::CMD_CLR_STATUS,
        sps_pkg::CMD_CLR_STATUS, sps_pkg::CMD_CLR_REPEAT,
        sps_pkg::CMD_CLR_NOT_ACKNOWLEDGED_FLAG, sps_pkg::CMD_CLR_STATUS};
    always #10 clk_i = ~clk_i;
    sps_line_model far (.clk_i(clk_i), .go_i(go), .chr_i(chr), .lvl_i(lvl),
        .done_o(done), .chr_o(rch), .mark_o(mk), .modem_o(mdm));
    sps_status uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .rx_char_done_i(done), .rx_char_i(rch), .rx_cmd_mark_i(mk),
        .rx_busy_i(busy), .break_edge_i(pv[0]), .frame_err_i(pv[1]),
        .parity_err_i(pv[2]), .repeat_max_i(pv[3]), .not_acknowledged_flag_i(pv[4]),
        .biphase_err_i(pv[5]), .underrun_i(pv[6]), .bit_tick_i(pv[7]),
        .tx_load_i(pv[8]), .tx_shift_empty_i(shm), .rx_dma_dec_i(pv[9]),
        .tx_dma_dec_i(pv[10]), .modem_i(mdm), .tx_holding_free_o(thf),
        .tx_fully_drained_o(tfd), .rx_char_available_o(rca),
        .tx_char_o(tco), .break_pending_o(bpo));
    function automatic logic [15:0] lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // oldest note against the data of each read
    always @(posedge clk_i) begin
        rd_d <= rd_i;
        if (rd_d) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("[ERR] rdata exp note got none");
            end else begin
                ce = exp_q.pop_front();
                cm = msk_q.pop_front();
                `CHK("rdata", ce, rdata_o & cm)
            end
        end
    end
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] ev,
        input logic [31:0] mv);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(ev);
        msk_q.push_back(mv);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    task automatic st(input int b, input logic v);
        rd(sps_pkg::CSR_OFS, {31'h0, v} << b, 32'h1 << b);
    endtask
    task automatic cmd(input int b);
        wr(sps_pkg::CTRL_CMD_OFS, 32'h1 << b);
    endtask
    task automatic pulse(input int i);
        @(posedge clk_i);
        pv[i] <= 1'b1;
        @(posedge clk_i);
        pv <= 11'h000;
    endtask
    task automatic rxc(input logic [9:0] c);
        @(posedge clk_i);
        chr <= c;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        $display("[ERR] run exp end got hang");
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(sps_pkg::CSR_OFS, 32'h1800, 32'h01ff3fe7);
        rd(32'h400a0f00, 32'h0, 32'hffffffff);
        $display("test reset done");
        cmd(sps_pkg::CMD_TXEN);
        rd(sps_pkg::CSR_OFS, 32'h202, 32'h202);
        `CHK("tx_free", 1'b1, thf)
        wr(sps_pkg::THR_OFS, 32'h1a5);
        rd(sps_pkg::CSR_OFS, 32'h0, 32'h202);
        `CHK("tx_char", 9'h1a5, tco)
        `CHK("tx_free", 1'b0, thf)
        @(posedge clk_i);
        pv[8] <= 1'b1;
        shm <= 1'b0;
        @(posedge clk_i);
        pv <= 11'h000;
        rd(sps_pkg::CSR_OFS, 32'h2, 32'h202);
        @(posedge clk_i);
        shm <= 1'b1;
        rd(sps_pkg::CSR_OFS, 32'h202, 32'h202);
        `CHK("tx_drained", 1'b1, tfd)
        cmd(sps_pkg::CMD_BREAK_BEGIN);
        st(sps_pkg::ST_TX_HOLDING_FREE, 1'b0);
        `CHK("break_pend", 1'b1, bpo)
        cmd(sps_pkg::CMD_BREAK_END);
        st(sps_pkg::ST_TX_HOLDING_FREE, 1'b1);
        cmd(sps_pkg::CMD_TXDIS);
        rd(sps_pkg::CSR_OFS, 32'h0, 32'h202);
        $display("test transmit done");
        cmd(sps_pkg::CMD_RXEN);
        c1 = {1'b1, rnd[8:0]};
        rxc(c1);
        st(sps_pkg::ST_RX_CHAR_AVAILABLE, 1'b1);
        `CHK("rx_avail", 1'b1, rca)
        rd(sps_pkg::RHR_OFS, {16'h0, c1[9], 6'h0, c1[8:0]}, 32'h81ff);
        st(sps_pkg::ST_RX_CHAR_AVAILABLE, 1'b0);
        rnd = lf(rnd);
        rxc({1'b0, rnd[15:7]});
        c1 = {1'b0, rnd[8:0]};
        rxc(c1);
        rd(sps_pkg::CSR_OFS, 32'h21, 32'h21);
        rd(sps_pkg::RHR_OFS, {23'h0, c1[8:0]}, 32'h81ff);
        cmd(sps_pkg::CMD_CLR_STATUS);
        st(sps_pkg::ST_OVR, 1'b0);
        @(posedge clk_i);
        busy <= 1'b1;
        cmd(sps_pkg::CMD_RXDIS);
        busy <= 1'b0;
        st(sps_pkg::ST_RX_CHAR_AVAILABLE, 1'b0);
        cmd(sps_pkg::CMD_RXEN);
        st(sps_pkg::ST_RX_CHAR_AVAILABLE, 1'b1);
        $display("test receive done");
        for (int i = 0; i < 6; i++) begin
            pulse(i);
            st(sb[i], 1'b1);
            st(sb[i], 1'b1);
            cmd(cb[i]);
            st(sb[i], 1'b0);
        end
        @(posedge clk_i);
        pv[1] <= 1'b1;
        addr_i <= sps_pkg::CTRL_CMD_OFS;
        wdata_i <= 32'h1 << sps_pkg::CMD_CLR_STATUS;
        wr_i <= 1'b1;
        @(posedge clk_i);
        pv <= 11'h000;
        wr_i <= 1'b0;
        st(sps_pkg::ST_FRAME, 1'b1);
        cmd(sps_pkg::CMD_CLR_STATUS);
        $display("test sticky done");
        wr(sps_pkg::RTOR_OFS, 32'h3);
        cmd(sps_pkg::CMD_ARM_TIMER);
        repeat (2) pulse(7);
        st(sps_pkg::ST_TOUT, 1'b0);
        pulse(7);
        st(sps_pkg::ST_TOUT, 1'b1);
        cmd(sps_pkg::CMD_ARM_TIMER);
        st(sps_pkg::ST_TOUT, 1'b0);
        wr(sps_pkg::RTOR_OFS, 32'h0);
        cmd(sps_pkg::CMD_ARM_TIMER);
        repeat (4) pulse(7);
        st(sps_pkg::ST_TOUT, 1'b0);
        $display("test timeout done");
        for (int k = 0; k < 2; k++) begin
            e = (k == 1) ? sps_pkg::ST_TX_DMA_COUNT_DONE : sps_pkg::ST_RX_DMA_COUNT_DONE;
            m = (k == 1) ? sps_pkg::ST_TX_DMA_BOTH_ZERO : sps_pkg::ST_RX_DMA_BOTH_ZERO;
            se = (32'h1 << e) | (32'h1 << m);
            wr((k == 1) ? sps_pkg::TCR_OFS : sps_pkg::RCR_OFS, 32'h2);
            rd(sps_pkg::CSR_OFS, 32'h0, se);
            pulse(9 + k);
            st(e, 1'b0);
            pulse(9 + k);
            rd(sps_pkg::CSR_OFS, se, se);
            wr((k == 1) ? sps_pkg::TNCR_OFS : sps_pkg::RNCR_OFS, 32'h0);
            st(e, 1'b0);
        end
        $display("test dma done");
        for (int j = 0; j < 4; j++) begin
            rnd = lf(rnd);
            nl = rnd[3:0] ^ 4'h1 << j;
            se = {8'h0, nl, nl ^ lvl, 16'h0};
            @(posedge clk_i);
            lvl <= nl;
            repeat (8) @(posedge clk_i);
            rd(sps_pkg::CSR_OFS, se, 32'h00ff0000);
            rd(sps_pkg::CSR_OFS, se & 32'h00f00000, 32'h00ff0000);
        end
        $display("test modem done");
        for (int k = 0; k < 2; k++) begin
            wr(sps_pkg::MODE_OFS, (k == 1) ? 32'hf : 32'he);
            rd(sps_pkg::CSR_OFS, 32'h0, 32'h017721c4);
            @(posedge clk_i);
            lvl[3] <= ~lvl[3];
            repeat (8) @(posedge clk_i);
            se = {8'h0, lvl[3], 3'h0, 1'b1, 19'h0};
            rd(sps_pkg::CSR_OFS, se, 32'h00ff0000);
            rd(sps_pkg::CSR_OFS, se & 32'h00800000, 32'h00ff0000);
            pulse(6);
            st(sps_pkg::ST_UNDER, 1'b1);
            cmd(sps_pkg::CMD_CLR_STATUS);
            st(sps_pkg::ST_UNDER, 1'b0);
        end
        wr(sps_pkg::MODE_OFS, 32'h0);
        $display("test spi done");
        repeat (4) @(posedge clk_i);
        if (exp_q.size() != 0) fails++;
        stop_test();
    end
endmodule
